// [cal_engine_model.sv]
/* Behavioural measurement engine facing the sequencer.
   Assumes the same clock; slow stretches the measurement. */
`timescale 1ns/10ps
module cal_engine_model #(
   parameter logic [23:0] OFS_V  = 24'h123456,
   parameter logic [23:0] GAIN_V = 24'h654321
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Sequencer side
   input  wire logic        cal_start,
   input  wire logic        slow,
   output logic             meas_done,
   output logic      [23:0] meas_offset,
   output logic      [23:0] meas_gain
);
   logic [5:0] left_ff;
   logic       busy_ff;
   // ==========================================================
   // Measurement timer; keeps running even if the run is abandoned
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_ff   <= 1'b0;
         left_ff   <= 6'h00;
         meas_done <= 1'b0;
      end else begin
         meas_done <= 1'b0;
         if (cal_start) begin
            busy_ff <= 1'b1;
            left_ff <= slow ? 6'h28 : 6'h04;
         end else if (busy_ff && left_ff == 6'h00) begin
            busy_ff   <= 1'b0;
            meas_done <= 1'b1;
         end else if (busy_ff) begin
            left_ff <= left_ff - 6'h01;
         end
      end
   end
   // Results are junk outside the done cycle
   assign meas_offset = meas_done ? OFS_V : ~OFS_V ^ {24{left_ff[0]}};
   assign meas_gain   = meas_done ? GAIN_V : ~GAIN_V ^ {24{left_ff[0]}};
endmodule // cal_engine_model

// [cal_seq_checker.sv]
/* Port checker for the mode sequencer.
   Assumes a bind to the top module; one clock domain. */
`timescale 1ns/10ps
module cal_seq_checker (
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset_n,
   // Register bus
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [5:0]  avs_address,
   input wire logic [31:0] avs_writedata,
   input wire logic        avs_waitrequest,
   // Converter side
   input wire logic        standby_req_n,
   input wire logic        ready,
   input wire logic        standby_active,
   input wire logic        modulator_reset,
   input wire logic        cal_start,
   input wire logic [1:0]  cal_kind,
   input wire logic        inputs_shorted,
   input wire logic        internal_full_scale,
   input wire logic        meas_done
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic mode_wr;
   assign mode_wr = avs_write && !avs_waitrequest && avs_address == cal_seq_pkg::MODE_OFS;
   // ==========================================================
   // Assertions
   chk_bus_answer: assert property ($rose(avs_read || avs_write) |->
      avs_waitrequest ##1 !avs_waitrequest) else $error("bus answer late");
   chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   chk_start_pulse: assert property (cal_start |=> !cal_start && ready)
      else $error("start pulse or ready wrong");
   chk_zs_shorted: assert property (cal_start && cal_kind == 2'h0 |->
      inputs_shorted && !internal_full_scale) else $error("inputs not shorted");
   chk_fs_internal: assert property (cal_start && cal_kind == 2'h1 |->
      internal_full_scale && !inputs_shorted) else $error("no internal signal");
   chk_sys_external: assert property (cal_start && cal_kind[1] |->
      !inputs_shorted && !internal_full_scale) else $error("system cal not external");
   // Pin standby freezes the run, so only a free run must finish
   chk_done_sync: assert property (ready && meas_done && standby_req_n
      && !standby_active && !mode_wr |-> ##2 (!ready && modulator_reset))
      else $error("no return to sync");
   chk_fall_sync: assert property ($fell(ready) && !$past(mode_wr)
      |-> modulator_reset) else $error("ready fell outside sync");
   chk_mode_stby: assert property (mode_wr &&
      avs_writedata[cal_seq_pkg::MODE_MSB:cal_seq_pkg::MODE_LSB] == cal_seq_pkg::MD_STBY
      |=> standby_active) else $error("code standby ignored");
   chk_pin_stby: assert property ((!standby_req_n) [*4] |-> standby_active)
      else $error("pin standby ignored");
   cover property (cal_start && cal_kind == 2'h3);
   cover property ($fell(ready));
   cover property (standby_active);
endmodule // cal_seq_checker

// [cal_seq_pkg.sv]
/*
 * Shared constants and types for the standby and calibration sequencer:
 * register offsets, mode field layout, mode codes, reset values, states.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
package cal_seq_pkg;

   // ==========================================================
   // Register map (byte addresses, one aligned word each)
   localparam int            ADDR_W       = 6;
   localparam logic [5:0]    MODE_OFS     = 6'h00;
   localparam logic [5:0]    STATUS_OFS   = 6'h04;
   localparam logic [5:0]    OFFSET_BASE  = 6'h08;
   localparam logic [5:0]    GAIN_BASE    = 6'h18;
   localparam logic [5:0]    GAIN_END     = 6'h28;

   // ==========================================================
   // Mode register layout and values after reset
   localparam int            MODE_MSB     = 15;
   localparam int            MODE_LSB     = 13;
   localparam int            CHAN_HIGH    = 1;
   localparam int            CHAN_LOW     = 0;
   localparam logic [15:0]   MODE_RESET   = 16'h01b0;
   localparam logic [23:0]   COEF_RESET   = 24'h800000;

   // ==========================================================
   // Operating mode codes
   localparam logic [2:0]    MD_SYNC      = 3'h0;
   localparam logic [2:0]    MD_CONT      = 3'h1;
   localparam logic [2:0]    MD_SINGLE    = 3'h2;
   localparam logic [2:0]    MD_STBY      = 3'h3;
   localparam logic [2:0]    MD_ZS_SELF   = 3'h4;
   localparam logic [2:0]    MD_FS_SELF   = 3'h5;
   localparam logic [2:0]    MD_ZS_SYS    = 3'h6;
   localparam logic [2:0]    MD_FS_SYS    = 3'h7;

   // ==========================================================
   // Status word bit positions
   localparam int            STAT_READY   = 0;
   localparam int            STAT_STBY    = 1;
   localparam int            STAT_SYNC    = 2;
   localparam int            STAT_CAL     = 3;

   // ==========================================================
   // Sequencer states
   typedef enum logic [4:0] {
      ST_SYNC = 5'b00001,
      ST_RUN  = 5'b00010,
      ST_STBY = 5'b00100,
      ST_CAL  = 5'b01000,
      ST_DONE = 5'b10000
   } seq_state_t;

endpackage

// [level_sync2.sv]
/*
 * Two-stage synchroniser for one level arriving from outside the clock domain.
 * Assumes the level is slow compared with clk; no pulse capture.
 */
`timescale 1ns/10ps
module level_sync2 #(
   parameter logic RESET_VAL = 1'b0
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Level in and out
   input  wire logic async_in,
   output logic      sync_out
);

   typedef struct packed {
      logic meta;
      logic held;
   } sync_regs_t;

   sync_regs_t r_ff;
   sync_regs_t nxt_r;

   // ==========================================================
   // First stage is read only by the second
   always_comb begin
      nxt_r      = r_ff;
      nxt_r.meta = async_in;
      nxt_r.held = r_ff.meta;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r_ff <= '{meta: RESET_VAL, held: RESET_VAL};
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign sync_out = r_ff.held;

endmodule // level_sync2

// [standby_and_calibration_sequencer.sv]
/*
 * Mode sequencer: mode register, standby, four calibration modes, coefficient
 * registers and ready indication, reached over Avalon-MM with waitrequest.
 * Assumes a measurement engine on clk that runs a calibration on cal_start
 * and pulses meas_done with its results; the standby pin is asynchronous.
 */
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
// What this block does
// - Mode code 011 puts the device in standby, same as the pin.
// - Standby pin gives standby but leaves the stored mode field untouched.
// - Code 100 starts zero-scale self-calibration, selected channel, inputs shorted.
// - Zero-scale self-calibration end writes offset coefficient, mode field 000, sync.
// - Code 101 starts full-scale self-calibration with internal full-scale signal.
// - Full-scale self-calibration end writes gain and offset, mode 000, sync.
// - Code 110 system zero-scale calibration updates only offset, then mode 000.
// - Code 111 system full-scale calibration updates only gain, then mode 000.
// - Ready pin and status bit high during calibration, low back in sync.
// - Mode field is the top three bits of the 16-bit mode register.
// - A new mode write abandons the current mode and starts the new one.
// - Sync mode holds modulator and filter in reset; it is the reset default.
`timescale 1ns/10ps
module standby_and_calibration_sequencer (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Avalon-MM slave
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // External standby request pin
   input  wire logic        standby_req_n,
   // Converter control
   output logic             ready,
   output logic             standby_active,
   output logic             modulator_reset,
   // Measurement engine
   output logic             cal_start,
   output logic      [1:0]  cal_kind,
   output logic      [1:0]  cal_channel,
   output logic             inputs_shorted,
   output logic             internal_full_scale,
   input  wire logic        meas_done,
   input  wire logic [23:0] meas_offset,
   input  wire logic [23:0] meas_gain
);

   typedef struct packed {
      cal_seq_pkg::seq_state_t state;
      logic [15:0]             mode;
      logic [3:0][23:0]        offs;
      logic [3:0][23:0]        gain;
      logic                    wait_rq;
      logic [31:0]             rdata;
      logic                    ready;
      logic                    standby;
      logic                    mod_reset;
      logic                    cal_start;
      logic [1:0]              cal_kind;
      logic [1:0]              cal_chan;
      logic                    shorted;
      logic                    int_fs;
   } seq_regs_t;

   seq_regs_t   r_ff;
   seq_regs_t   nxt_r;
   logic        stby_pin_sync_n;
   logic        pin_stby;
   logic [1:0]  off_idx;
   logic [1:0]  gain_idx;

   // ==========================================================
   // Standby pin synchroniser
   level_sync2 #(
      .RESET_VAL (1'b1)
   ) u_stby_sync (
      .clk      (clk),
      .reset_n  (reset_n),
      .async_in (standby_req_n),
      .sync_out (stby_pin_sync_n)
   );

   assign pin_stby = ~stby_pin_sync_n;
   assign off_idx  = 2'((avs_address - cal_seq_pkg::OFFSET_BASE) >> 2);
   assign gain_idx = 2'((avs_address - cal_seq_pkg::GAIN_BASE) >> 2);

   function automatic logic [31:0] merge_lanes(input logic [31:0] old_val,
                                               input logic [31:0] wdata,
                                               input logic [3:0]  be);
      logic [31:0] res;
      res = old_val;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wdata[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // ==========================================================
   // Next state
   always_comb begin
      logic        take;
      logic        mode_wr;
      logic [15:0] new_mode;
      logic [2:0]  code;
      logic [31:0] merged;
      take     = 1'b0;
      mode_wr  = 1'b0;
      new_mode = r_ff.mode;
      code     = 3'h0;
      merged   = 32'h0;
      nxt_r    = r_ff;

      nxt_r.cal_start = 1'b0;

      // One wait cycle, then the answer; the request completes on the
      // edge where waitrequest is seen low.
      nxt_r.wait_rq = 1'b1;
      if ((avs_read || avs_write) && r_ff.wait_rq) begin
         nxt_r.wait_rq = 1'b0;
         nxt_r.rdata   = 32'h0;
         if (avs_address == cal_seq_pkg::MODE_OFS) begin
            nxt_r.rdata = {16'h0, r_ff.mode};
         end else if (avs_address == cal_seq_pkg::STATUS_OFS) begin
            nxt_r.rdata[cal_seq_pkg::STAT_READY] = r_ff.ready;
            nxt_r.rdata[cal_seq_pkg::STAT_STBY]  = r_ff.standby;
            nxt_r.rdata[cal_seq_pkg::STAT_SYNC]  = r_ff.mod_reset;
            nxt_r.rdata[cal_seq_pkg::STAT_CAL]   = (r_ff.state == cal_seq_pkg::ST_CAL);
         end else if (avs_address >= cal_seq_pkg::OFFSET_BASE &&
                      avs_address <  cal_seq_pkg::GAIN_BASE) begin
            nxt_r.rdata = {8'h0, r_ff.offs[off_idx]};
         end else if (avs_address >= cal_seq_pkg::GAIN_BASE &&
                      avs_address <  cal_seq_pkg::GAIN_END) begin
            nxt_r.rdata = {8'h0, r_ff.gain[gain_idx]};
         end
      end
      take = avs_write && !r_ff.wait_rq;

      // Register writes; unmapped addresses and status are ignored
      if (take && avs_address == cal_seq_pkg::MODE_OFS) begin
         mode_wr  = 1'b1;
         merged   = merge_lanes({16'h0, r_ff.mode}, avs_writedata, avs_byteenable);
         new_mode = merged[15:0];
      end else if (take && avs_address >= cal_seq_pkg::OFFSET_BASE &&
                   avs_address < cal_seq_pkg::GAIN_BASE) begin
         merged = merge_lanes({8'h0, r_ff.offs[off_idx]}, avs_writedata,
                              {1'b0, avs_byteenable[2:0]});
         nxt_r.offs[off_idx] = merged[23:0];
      end else if (take && avs_address >= cal_seq_pkg::GAIN_BASE &&
                   avs_address < cal_seq_pkg::GAIN_END) begin
         merged = merge_lanes({8'h0, r_ff.gain[gain_idx]}, avs_writedata,
                              {1'b0, avs_byteenable[2:0]});
         nxt_r.gain[gain_idx] = merged[23:0];
      end

      // Sequencer; a mode write below overrides whatever happens here
      case (r_ff.state)
         cal_seq_pkg::ST_CAL: begin
            // meas_done from the engine is ignored while the pin holds standby
            if (meas_done && !pin_stby && !mode_wr) begin
               case (r_ff.cal_kind)
                  cal_seq_pkg::MD_ZS_SELF[1:0]: begin
                     nxt_r.offs[r_ff.cal_chan] = meas_offset;
                  end
                  cal_seq_pkg::MD_FS_SELF[1:0]: begin
                     nxt_r.offs[r_ff.cal_chan] = meas_offset;
                     nxt_r.gain[r_ff.cal_chan] = meas_gain;
                  end
                  cal_seq_pkg::MD_ZS_SYS[1:0]: begin
                     nxt_r.offs[r_ff.cal_chan] = meas_offset;
                  end
                  default: begin
                     nxt_r.gain[r_ff.cal_chan] = meas_gain;
                  end
               endcase
               // Commit first, completion shows a cycle later
               nxt_r.state = cal_seq_pkg::ST_DONE;
            end
         end
         cal_seq_pkg::ST_DONE: begin
            nxt_r.mode[cal_seq_pkg::MODE_MSB:cal_seq_pkg::MODE_LSB] =
               cal_seq_pkg::MD_SYNC;
            nxt_r.ready = 1'b0;
            nxt_r.state = cal_seq_pkg::ST_SYNC;
         end
         default: begin
         end
      endcase

      // New mode takes over straight after the write
      if (mode_wr) begin
         nxt_r.mode  = new_mode;
         code        = new_mode[cal_seq_pkg::MODE_MSB:cal_seq_pkg::MODE_LSB];
         nxt_r.ready = 1'b0;
         case (code)
            cal_seq_pkg::MD_SYNC: begin
               nxt_r.state = cal_seq_pkg::ST_SYNC;
            end
            cal_seq_pkg::MD_CONT, cal_seq_pkg::MD_SINGLE: begin
               nxt_r.state = cal_seq_pkg::ST_RUN;
            end
            cal_seq_pkg::MD_STBY: begin
               nxt_r.state = cal_seq_pkg::ST_STBY;
            end
            default: begin
               nxt_r.state     = cal_seq_pkg::ST_CAL;
               nxt_r.cal_start = 1'b1;
               nxt_r.cal_kind  = code[1:0];
               nxt_r.cal_chan  = {new_mode[cal_seq_pkg::CHAN_HIGH],
                                  new_mode[cal_seq_pkg::CHAN_LOW]};
               nxt_r.ready     = 1'b1;
            end
         endcase
      end

      // Registered pin levels follow the next state
      nxt_r.standby   = pin_stby || (nxt_r.state == cal_seq_pkg::ST_STBY);
      nxt_r.mod_reset = (nxt_r.state == cal_seq_pkg::ST_SYNC) ||
                        (nxt_r.state == cal_seq_pkg::ST_DONE);
      nxt_r.shorted   = (nxt_r.state == cal_seq_pkg::ST_CAL) &&
                        (nxt_r.cal_kind == cal_seq_pkg::MD_ZS_SELF[1:0]);
      nxt_r.int_fs    = (nxt_r.state == cal_seq_pkg::ST_CAL) &&
                        (nxt_r.cal_kind == cal_seq_pkg::MD_FS_SELF[1:0]);
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r_ff.state     <= cal_seq_pkg::ST_SYNC;
         r_ff.mode      <= cal_seq_pkg::MODE_RESET;
         r_ff.offs      <= {4{cal_seq_pkg::COEF_RESET}};
         r_ff.gain      <= {4{cal_seq_pkg::COEF_RESET}};
         r_ff.wait_rq   <= 1'b1;
         r_ff.rdata     <= 32'h0;
         r_ff.ready     <= 1'b0;
         r_ff.standby   <= 1'b0;
         r_ff.mod_reset <= 1'b1;
         r_ff.cal_start <= 1'b0;
         r_ff.cal_kind  <= 2'h0;
         r_ff.cal_chan  <= 2'h0;
         r_ff.shorted   <= 1'b0;
         r_ff.int_fs    <= 1'b0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign avs_readdata        = r_ff.rdata;
   assign avs_waitrequest     = r_ff.wait_rq;
   assign ready               = r_ff.ready;
   assign standby_active      = r_ff.standby;
   assign modulator_reset     = r_ff.mod_reset;
   assign cal_start           = r_ff.cal_start;
   assign cal_kind            = r_ff.cal_kind;
   assign cal_channel         = r_ff.cal_chan;
   assign inputs_shorted      = r_ff.shorted;
   assign internal_full_scale = r_ff.int_fs;

endmodule // standby_and_calibration_sequencer

// [testbench.sv]
/* Self-checking bench for the mode sequencer.
   Assumes the engine model and checker files are compiled first. */
`timescale 1ns/10ps
module testbench;
   localparam logic [23:0] OFS_V  = 24'h123456;
   localparam logic [23:0] GAIN_V = 24'h654321;
   logic        clk, reset_n, avs_read, avs_write, avs_waitrequest, standby_req_n;
   logic        ready, standby_active, modulator_reset, cal_start, meas_done, slow;
   logic [5:0]  avs_address;
   logic [3:0]  avs_byteenable;
   logic [1:0]  cal_channel;
   logic [31:0] avs_writedata, avs_readdata;
   logic [23:0] meas_offset, meas_gain;
   int          miscompares, num_checks;
   standby_and_calibration_sequencer dut (.clk, .reset_n, .avs_address, .avs_read,
      .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
      .standby_req_n, .ready, .standby_active, .modulator_reset, .cal_start,
      .cal_kind(), .cal_channel, .inputs_shorted(), .internal_full_scale(),
      .meas_done, .meas_offset, .meas_gain);
   cal_engine_model #(.OFS_V(OFS_V), .GAIN_V(GAIN_V)) engine (.clk, .reset_n,
      .cal_start, .slow, .meas_done, .meas_offset, .meas_gain);
   always #12.5 clk = ~clk;
   // ==========================================================
   // Reporting and bus tasks
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wt();
      int n;
      n = 0;
      do begin @(posedge clk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0) begin miscompares++; results(); end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a; avs_writedata <= d; avs_write <= 1'b1;
      wt();
      avs_write <= 1'b0;
   endtask
   task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] e);
      @(posedge clk);
      avs_address <= a; avs_read <= 1'b1;
      wt();
      cmp(nm, e, avs_readdata);
      avs_read <= 1'b0;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      rdc("mode", cal_seq_pkg::MODE_OFS, {16'h0, cal_seq_pkg::MODE_RESET});
      rdc("status", cal_seq_pkg::STATUS_OFS, 32'h4);
      rdc("offset0", cal_seq_pkg::OFFSET_BASE, {8'h0, cal_seq_pkg::COEF_RESET});
      rdc("unmapped", 6'h3c, 32'h0);
   endtask
   task automatic t_cal(input logic [2:0] code, input logic [1:0] ch);
      int n;
      n = 0;
      wr(cal_seq_pkg::MODE_OFS, {16'h0, code, 11'h0, ch});
      #1 cmp("ready", 32'h1, {31'h0, ready});
      cmp("channel", {30'h0, ch}, {30'h0, cal_channel});
      rdc("status_cal", cal_seq_pkg::STATUS_OFS, 32'h9);
      while (ready !== 1'b0 && n < 200) begin @(posedge clk); #1 n++; end
      if (ready !== 1'b0) begin miscompares++; results(); end
      rdc("status_done", cal_seq_pkg::STATUS_OFS, 32'h4);
      rdc("mode_clr", cal_seq_pkg::MODE_OFS, {30'h0, ch});
      rdc("offset", cal_seq_pkg::OFFSET_BASE + {2'b0, ch, 2'b0},
          {8'h0, code == 3'h7 ? cal_seq_pkg::COEF_RESET : OFS_V});
      rdc("gain", cal_seq_pkg::GAIN_BASE + {2'b0, ch, 2'b0},
          {8'h0, code[0] ? GAIN_V : cal_seq_pkg::COEF_RESET});
   endtask
   task automatic t_standby();
      wr(cal_seq_pkg::MODE_OFS, 32'h6000);
      #1 cmp("stby_code", 32'h1, {31'h0, standby_active});
      wr(cal_seq_pkg::MODE_OFS, 32'h2000);
      standby_req_n <= 1'b0;
      repeat (5) @(posedge clk);
      #1 cmp("stby_pin", 32'h1, {31'h0, standby_active});
      rdc("status_pin", cal_seq_pkg::STATUS_OFS, 32'h2);
      rdc("mode_kept", cal_seq_pkg::MODE_OFS, 32'h2000);
      standby_req_n <= 1'b1;
      repeat (5) @(posedge clk);
      #1 cmp("stby_off", 32'h0, {31'h0, standby_active});
      wr(cal_seq_pkg::MODE_OFS, 32'h4000);
      rdc("status_run", cal_seq_pkg::STATUS_OFS, 32'h0);
      wr(cal_seq_pkg::MODE_OFS, 32'h0000);
      rdc("status_sync", cal_seq_pkg::STATUS_OFS, 32'h4);
   endtask
   // Late result of an abandoned run must not land
   task automatic t_abandon();
      wr(cal_seq_pkg::GAIN_BASE, 32'h111);
      slow <= 1'b1;
      wr(cal_seq_pkg::MODE_OFS, 32'he000);
      repeat (5) @(posedge clk);
      wr(cal_seq_pkg::MODE_OFS, 32'h2000);
      #1 cmp("ready_abort", 32'h0, {31'h0, ready});
      repeat (60) @(posedge clk);
      rdc("gain_kept", cal_seq_pkg::GAIN_BASE, 32'h111);
      rdc("mode_run", cal_seq_pkg::MODE_OFS, 32'h2000);
   endtask
   initial begin
      clk = 1'b0; reset_n = 1'b0; avs_address = 6'h00; avs_read = 1'b0;
      avs_write = 1'b0; avs_byteenable = 4'hf; avs_writedata = 32'h0;
      standby_req_n = 1'b1; slow = 1'b0; miscompares = 0; num_checks = 0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_cal(3'h4, 2'h0);
      t_cal(3'h5, 2'h1);
      t_cal(3'h6, 2'h2);
      t_cal(3'h7, 2'h3);
      t_standby();
      t_abandon();
      results();
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      results();
   end
endmodule // testbench
bind standby_and_calibration_sequencer cal_seq_checker u_chk (.clk, .reset_n,
   .avs_read, .avs_write, .avs_address, .avs_writedata, .avs_waitrequest,
   .standby_req_n, .ready, .standby_active, .modulator_reset, .cal_start, .cal_kind,
   .inputs_shorted, .internal_full_scale, .meas_done);
